// [rtl/dual_pwm_pkg.sv]
package dual_pwm_pkg;

    // Register indices as printed (not word aligned: plain port, printed offsets)
    localparam logic [11:0] PWM_B_DUTY_OFS     = 12'hf9f;
    localparam logic [11:0] PWM_B_CONTROL_OFS  = 12'hfa1;
    localparam logic [11:0] PWM_A_DUTY_OFS     = 12'hfa2;
    localparam logic [11:0] PWM_A_CONTROL_OFS  = 12'hfa4;
    localparam logic [11:0] TIMER_SEL_OFS      = 12'hfad;
    // Own registers: period limit per timer, and a timer run control
    localparam logic [11:0] TIMER_A_LIMIT_OFS  = 12'hfb0;
    localparam logic [11:0] TIMER_B_LIMIT_OFS  = 12'hfb1;
    localparam logic [11:0] TIMER_C_LIMIT_OFS  = 12'hfb2;
    localparam logic [11:0] TIMER_RUN_OFS      = 12'hfb3;

    // Control register fields
    localparam int CTL_ENABLE_BIT  = 7;
    localparam int CTL_LEVEL_BIT   = 5;
    localparam int CTL_INVERT_BIT  = 4;

    // Duty register fields
    localparam int DUTY_LOW_MSB    = 7;
    localparam int DUTY_LOW_LSB    = 6;
    localparam int DUTY_HIGH_MSB   = 15;
    localparam int DUTY_HIGH_LSB   = 8;

    // Timer select fields
    localparam int SEL_B_LSB       = 6;
    localparam int SEL_A_LSB       = 4;
    localparam int SEL_CAP2_LSB    = 2;
    localparam int SEL_CAP1_LSB    = 0;

    // Reset values
    localparam logic [7:0] TIMER_SEL_RESET   = 8'h55;
    localparam logic [7:0] TIMER_LIMIT_RESET = 8'hff;
    localparam logic [7:0] CONTROL_RESET     = 8'h00;

    // Timer select codes
    localparam logic [1:0] SEL_RESERVED = 2'h0;
    localparam logic [1:0] SEL_TIMER_A  = 2'h1;
    localparam logic [1:0] SEL_TIMER_B  = 2'h2;
    localparam logic [1:0] SEL_TIMER_C  = 2'h3;

    // Timers tick at system clock divided by four
    localparam int          TICK_DIV    = 4;
    localparam logic [1:0]  TICK_LAST   = 2'(TICK_DIV - 1);

endpackage

// [rtl/dual_pwm_with_timer_select.sv]
`timescale 1ns/1ps

// Operation
// RL1: Channel runs only while enable bit set
// RL2: Invert bit flips channel output waveform
// RL3: Control bit 5 reads current output level
// RL4: Duty bits 15:8 hold duty MSBs
// RL5: Duty bits 7:6 hold LSBs, rest unused
// RL6: Duty fields untouched by reset
// RL7: Bits 7:6 pick timer for channel B
// RL8: Bits 5:4 pick timer for channel A
// RL9: Bits 3:2 pick capture unit two timers
// RL10: Bits 1:0 pick capture unit one timers
// RL11: Set at count clear, clear at duty match
// RL12: Duty buffered, loaded at period match
// RL13: Sleep freezes timers and channel state
// RL14: Disabled or reserved select forces inactive
module dual_pwm_with_timer_select #(
    parameter int ADDR_W = 12
) (
    input  wire logic              i_clock,
    input  wire logic              i_srst,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [15:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    input  wire logic              i_sleep,
    output logic      [15:0]       o_rdata,
    output logic                   o_pwm_a,
    output logic                   o_pwm_b,
    output logic      [1:0]        o_cap1_timer_sel,
    output logic      [1:0]        o_cap2_timer_sel
);

    // Elaboration check: the register map needs twelve address bits
    if (ADDR_W < 12)
    begin
        $error("ADDR_W must be at least 12");
    end

    // Register state
    logic [7:0] ctl_a_r;
    logic [7:0] ctl_b_r;
    logic [9:0] duty_a_r;
    logic [9:0] duty_b_r;
    logic [9:0] work_a_r;
    logic [9:0] work_b_r;
    logic [7:0] sel_r;
    logic [7:0] limit_r [3];
    logic [7:0] count_r [3];
    logic [1:0] phase_r;
    logic       run_r;
    logic       live_a_r;
    logic       live_b_r;

    logic       frozen;
    logic       tick;
    logic [2:0] wrap;
    logic [9:0] base_a;
    logic [9:0] base_b;
    logic       wrap_a;
    logic       wrap_b;
    logic [7:0] lim_a;
    logic [7:0] lim_b;
    logic       level_a_nxt;
    logic       level_b_nxt;

    function automatic logic [1:0] timer_index(input logic [1:0] code);
        return (code == dual_pwm_pkg::SEL_RESERVED) ? 2'h0 : 2'(code - 2'h1);
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
        return a == ADDR_W'(ofs);
    endfunction

    // Sleep stops the tick divider and so every count
    assign frozen = i_sleep | ~run_r; // [RL13]
    assign tick   = ~frozen && phase_r == dual_pwm_pkg::TICK_LAST;

    // Tick divider: timers advance at clock over four
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            phase_r <= 2'h0;
        end
        else if (!frozen)
        begin
            phase_r <= 2'(phase_r + 2'h1);
        end
    end

    // Three 8-bit period timers, cleared on limit match
    always_ff @(posedge i_clock)
    begin
        for (int t = 0; t < 3; t++)
        begin
            if (i_srst)
            begin
                count_r[t] <= 8'h00;
            end
            else if (tick)
            begin
                count_r[t] <= wrap[t] ? 8'h00 : 8'(count_r[t] + 8'h01);
            end
        end
    end

    always_comb
    begin
        for (int t = 0; t < 3; t++)
        begin
            wrap[t] = count_r[t] == limit_r[t];
        end
    end

    // Selected timer per channel; reserved code reads as timer a but is gated
    always_comb
    begin
        base_a = {count_r[timer_index(sel_r[dual_pwm_pkg::SEL_A_LSB +: 2])], phase_r}; // [RL8]
        base_b = {count_r[timer_index(sel_r[dual_pwm_pkg::SEL_B_LSB +: 2])], phase_r}; // [RL7]
        lim_a  = limit_r[timer_index(sel_r[dual_pwm_pkg::SEL_A_LSB +: 2])];
        lim_b  = limit_r[timer_index(sel_r[dual_pwm_pkg::SEL_B_LSB +: 2])];
        wrap_a = tick && base_a[9:2] == lim_a;
        wrap_b = tick && base_b[9:2] == lim_b;
    end

    // Software writes; duty fields have no reset so they survive it
    always_ff @(posedge i_clock)
    begin
        if (i_wr && hit(i_addr, dual_pwm_pkg::PWM_A_DUTY_OFS))
        begin
            duty_a_r <= {i_wdata[dual_pwm_pkg::DUTY_HIGH_MSB:dual_pwm_pkg::DUTY_HIGH_LSB],
                         i_wdata[dual_pwm_pkg::DUTY_LOW_MSB:dual_pwm_pkg::DUTY_LOW_LSB]}; // [RL4] [RL5] [RL6]
        end
        if (i_wr && hit(i_addr, dual_pwm_pkg::PWM_B_DUTY_OFS))
        begin
            duty_b_r <= {i_wdata[dual_pwm_pkg::DUTY_HIGH_MSB:dual_pwm_pkg::DUTY_HIGH_LSB],
                         i_wdata[dual_pwm_pkg::DUTY_LOW_MSB:dual_pwm_pkg::DUTY_LOW_LSB]}; // [RL4] [RL5]
        end
    end

    // Working copies load only at the period match; reset clears them so no unknown reaches a pin
    always_ff @(posedge i_clock)
    begin
        if (wrap_a || i_srst)
        begin
            work_a_r <= i_srst ? 10'h000 : duty_a_r; // [RL12]
        end
        if (wrap_b || i_srst)
        begin
            work_b_r <= i_srst ? 10'h000 : duty_b_r; // [RL12]
        end
    end

    // Control, select, limit and run registers
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            ctl_a_r <= dual_pwm_pkg::CONTROL_RESET;
            ctl_b_r <= dual_pwm_pkg::CONTROL_RESET;
            sel_r   <= dual_pwm_pkg::TIMER_SEL_RESET;
            run_r   <= 1'b0;
            for (int t = 0; t < 3; t++)
            begin
                limit_r[t] <= dual_pwm_pkg::TIMER_LIMIT_RESET;
            end
        end
        else if (i_wr)
        begin
            if (hit(i_addr, dual_pwm_pkg::PWM_A_CONTROL_OFS))
            begin
                ctl_a_r <= i_wdata[7:0] & 8'h90; // Level bit is read-only
            end
            if (hit(i_addr, dual_pwm_pkg::PWM_B_CONTROL_OFS))
            begin
                ctl_b_r <= i_wdata[7:0] & 8'h90;
            end
            if (hit(i_addr, dual_pwm_pkg::TIMER_SEL_OFS))
            begin
                sel_r <= i_wdata[7:0]; // [RL9] [RL10]
            end
            if (hit(i_addr, dual_pwm_pkg::TIMER_A_LIMIT_OFS))
            begin
                limit_r[0] <= i_wdata[7:0];
            end
            if (hit(i_addr, dual_pwm_pkg::TIMER_B_LIMIT_OFS))
            begin
                limit_r[1] <= i_wdata[7:0];
            end
            if (hit(i_addr, dual_pwm_pkg::TIMER_C_LIMIT_OFS))
            begin
                limit_r[2] <= i_wdata[7:0];
            end
            if (hit(i_addr, dual_pwm_pkg::TIMER_RUN_OFS))
            begin
                run_r <= i_wdata[0];
            end
        end
    end

    // Waveform level before polarity; duty at or above period never clears
    always_comb
    begin
        level_a_nxt = live_a_r;
        level_b_nxt = live_b_r;
        if (!frozen)
        begin
            if (base_a == 10'h000)
            begin
                level_a_nxt = work_a_r != 10'h000; // [RL11]
            end
            else if (base_a == work_a_r)
            begin
                level_a_nxt = 1'b0; // [RL11]
            end
            if (base_b == 10'h000)
            begin
                level_b_nxt = work_b_r != 10'h000;
            end
            else if (base_b == work_b_r)
            begin
                level_b_nxt = 1'b0;
            end
        end
    end

    // Channel level state, held idle while disabled
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            live_a_r <= 1'b0;
            live_b_r <= 1'b0;
        end
        else
        begin
            live_a_r <= ctl_a_r[dual_pwm_pkg::CTL_ENABLE_BIT] & level_a_nxt; // [RL1]
            live_b_r <= ctl_b_r[dual_pwm_pkg::CTL_ENABLE_BIT] & level_b_nxt; // [RL1]
        end
    end

    // Pins: gated then inverted; disabled or reserved shows inactive level
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_pwm_a <= 1'b0;
            o_pwm_b <= 1'b0;
        end
        else
        begin
            o_pwm_a <= (live_a_r && sel_r[dual_pwm_pkg::SEL_A_LSB +: 2] != dual_pwm_pkg::SEL_RESERVED)
                       ^ ctl_a_r[dual_pwm_pkg::CTL_INVERT_BIT]; // [RL2] [RL14]
            o_pwm_b <= (live_b_r && sel_r[dual_pwm_pkg::SEL_B_LSB +: 2] != dual_pwm_pkg::SEL_RESERVED)
                       ^ ctl_b_r[dual_pwm_pkg::CTL_INVERT_BIT]; // [RL2] [RL14]
        end
    end

    // Capture unit timer pair codes go unchanged to the capture units through one register stage
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_cap1_timer_sel <= dual_pwm_pkg::SEL_TIMER_A;
            o_cap2_timer_sel <= dual_pwm_pkg::SEL_TIMER_A;
        end
        else
        begin
            o_cap1_timer_sel <= sel_r[dual_pwm_pkg::SEL_CAP1_LSB +: 2]; // [RL10]
            o_cap2_timer_sel <= sel_r[dual_pwm_pkg::SEL_CAP2_LSB +: 2]; // [RL9]
        end
    end

    // Read port, data one cycle after the strobe, zero otherwise
    always_ff @(posedge i_clock)
    begin
        if (i_srst || !i_rd)
        begin
            o_rdata <= 16'h0000;
        end
        else if (hit(i_addr, dual_pwm_pkg::PWM_A_CONTROL_OFS))
        begin
            o_rdata <= {8'h00, ctl_a_r[7:6], o_pwm_a, ctl_a_r[4:0]}; // [RL3]
        end
        else if (hit(i_addr, dual_pwm_pkg::PWM_B_CONTROL_OFS))
        begin
            o_rdata <= {8'h00, ctl_b_r[7:6], o_pwm_b, ctl_b_r[4:0]}; // [RL3]
        end
        else if (hit(i_addr, dual_pwm_pkg::PWM_A_DUTY_OFS))
        begin
            o_rdata <= {duty_a_r[9:2], duty_a_r[1:0], 6'h00}; // [RL5]
        end
        else if (hit(i_addr, dual_pwm_pkg::PWM_B_DUTY_OFS))
        begin
            o_rdata <= {duty_b_r[9:2], duty_b_r[1:0], 6'h00};
        end
        else if (hit(i_addr, dual_pwm_pkg::TIMER_SEL_OFS))
        begin
            o_rdata <= {8'h00, sel_r};
        end
        else if (hit(i_addr, dual_pwm_pkg::TIMER_A_LIMIT_OFS))
        begin
            o_rdata <= {8'h00, limit_r[0]};
        end
        else if (hit(i_addr, dual_pwm_pkg::TIMER_B_LIMIT_OFS))
        begin
            o_rdata <= {8'h00, limit_r[1]};
        end
        else if (hit(i_addr, dual_pwm_pkg::TIMER_C_LIMIT_OFS))
        begin
            o_rdata <= {8'h00, limit_r[2]};
        end
        else if (hit(i_addr, dual_pwm_pkg::TIMER_RUN_OFS))
        begin
            o_rdata <= {15'h0000, run_r};
        end
        else
        begin
            o_rdata <= 16'h0000;
        end
    end

    // Checks
    sequence period_match_a;
        wrap_a;
    endsequence

    disabled_idle_a: assert property (@(posedge i_clock) disable iff (i_srst) // [RL1]
        !ctl_a_r[dual_pwm_pkg::CTL_ENABLE_BIT] |=> !live_a_r)
        else $error("disabled channel a still active");

    polarity_out_a: assert property (@(posedge i_clock) disable iff (i_srst) // [RL2] [RL14]
        (!ctl_a_r[dual_pwm_pkg::CTL_ENABLE_BIT] && $stable(ctl_a_r))
        |=> o_pwm_a == $past(ctl_a_r[dual_pwm_pkg::CTL_INVERT_BIT]))
        else $error("idle level does not follow invert bit");

    level_read_a: assert property (@(posedge i_clock) disable iff (i_srst) // [RL3]
        (i_rd && hit(i_addr, dual_pwm_pkg::PWM_A_CONTROL_OFS))
        |=> o_rdata[dual_pwm_pkg::CTL_LEVEL_BIT] == $past(o_pwm_a))
        else $error("level bit readback wrong");

    duty_load_a: assert property (@(posedge i_clock) disable iff (i_srst) // [RL12]
        period_match_a |=> work_a_r == $past(duty_a_r))
        else $error("working duty not loaded at match");

    duty_hold_a: assert property (@(posedge i_clock) disable iff (i_srst) // [RL12]
        !wrap_a |=> $stable(work_a_r))
        else $error("working duty changed mid period");

    sleep_freeze_a: assert property (@(posedge i_clock) disable iff (i_srst) // [RL13]
        (i_sleep && $past(i_sleep)) |=> $stable(count_r[0]) && $stable(phase_r))
        else $error("timer moved in sleep");

    reserved_idle_a: assert property (@(posedge i_clock) disable iff (i_srst) // [RL14] [RL8]
        (sel_r[dual_pwm_pkg::SEL_A_LSB +: 2] == dual_pwm_pkg::SEL_RESERVED)
        |=> o_pwm_a == $past(ctl_a_r[dual_pwm_pkg::CTL_INVERT_BIT]))
        else $error("reserved select drives channel a");

    cap_select_a: assert property (@(posedge i_clock) disable iff (i_srst) // [RL9] [RL10]
        1'b1 |=> o_cap1_timer_sel == $past(sel_r[1:0]) && o_cap2_timer_sel == $past(sel_r[3:2]))
        else $error("capture select not forwarded");

    match_clear_a: assert property (@(posedge i_clock) disable iff (i_srst) // [RL11]
        (!frozen && base_a == work_a_r && base_a != 10'h000) |=> !live_a_r)
        else $error("output not cleared at duty match");

endmodule

// [dv/pwm_pin_monitor.sv]
`timescale 1ns/1ps

// Far-side load on a pin: counts high cycles since the last clear
module pwm_pin_monitor (
    input  wire logic i_clock,
    input  wire logic i_pin,
    input  wire logic i_clear,
    output integer    o_high
);
    // A registered count keeps the bench free of sampling races; a four-state count lets an unknown pin show
    always_ff @(posedge i_clock)
    begin
        if (i_clear)
            o_high <= 0;
        else
            o_high <= o_high + {31'h0, i_pin};
    end
endmodule

// [dv/dual_pwm_with_timer_select_bench.sv]
`timescale 1ns/1ps

module dual_pwm_with_timer_select_bench;
    logic        i_clock = 1'b0;
    logic        i_srst  = 1'b1;
    logic [11:0] i_addr  = 12'h000;
    logic [15:0] i_wdata = 16'h0000;
    logic        i_wr    = 1'b0;
    logic        i_rd    = 1'b0;
    logic        i_sleep = 1'b0;
    logic [15:0] o_rdata;
    logic        o_pwm_a;
    logic        o_pwm_b;
    logic [1:0]  o_cap1_timer_sel;
    logic [1:0]  o_cap2_timer_sel;
    logic        clr_a   = 1'b0;
    logic        clr_b   = 1'b0;
    integer      high_a;
    integer      high_b;
    int          num_errors = 0;
    int          checks     = 0;
    logic [15:0] rd_val;
    logic        pin_now;

    dual_pwm_with_timer_select dut (
        .i_clock          (i_clock),
        .i_srst           (i_srst),
        .i_addr           (i_addr),
        .i_wdata          (i_wdata),
        .i_wr             (i_wr),
        .i_rd             (i_rd),
        .i_sleep          (i_sleep),
        .o_rdata          (o_rdata),
        .o_pwm_a          (o_pwm_a),
        .o_pwm_b          (o_pwm_b),
        .o_cap1_timer_sel (o_cap1_timer_sel),
        .o_cap2_timer_sel (o_cap2_timer_sel)
    );
    pwm_pin_monitor mon_a (.i_clock(i_clock), .i_pin(o_pwm_a), .i_clear(clr_a), .o_high(high_a));
    pwm_pin_monitor mon_b (.i_clock(i_clock), .i_pin(o_pwm_b), .i_clear(clr_b), .o_high(high_b));

    // 100 MHz clock
    initial
    begin
        forever #5 i_clock = ~i_clock;
    end

    task automatic complete_run;
        $display("errors %0d, checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_cnt(input integer got, input integer exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe, then a released cycle
    task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [11:0] a, output logic [15:0] d);
        @(posedge i_clock);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd   <= 1'b0;
        #1 d = o_rdata;
    endtask

    // Ten-bit duty packed into the register layout
    function automatic logic [15:0] duty_word(input logic [9:0] d);
        return {d[9:2], d[1:0], 6'h00};
    endfunction

    // High cycles of both pins over 64 clocks, a whole number of periods
    task automatic measure(input int exp_a, input int exp_b);
        repeat (100) @(posedge i_clock);
        clr_a <= 1'b1;
        clr_b <= 1'b1;
        @(posedge i_clock);
        clr_a <= 1'b0;
        clr_b <= 1'b0;
        repeat (64) @(posedge i_clock);
        #1;
        if (exp_a >= 0) check_cnt(high_a, exp_a);
        if (exp_b >= 0) check_cnt(high_b, exp_b);
    endtask

    // Watchdog well beyond the expected run length
    initial
    begin
        #500000;
        num_errors++;
        complete_run();
    end

    initial
    begin
        repeat (3) @(posedge i_clock);
        i_srst <= 1'b0;
        rd_reg(dual_pwm_pkg::TIMER_SEL_OFS, rd_val);
        check_val(rd_val, 16'h0055);
        rd_reg(dual_pwm_pkg::PWM_A_CONTROL_OFS, rd_val);
        check_val(rd_val, 16'h0000);
        check_val({14'h0, o_cap1_timer_sel}, 16'h0001);
        check_val({14'h0, o_cap2_timer_sel}, 16'h0001);
        rd_reg(12'hf00, rd_val);
        check_val(rd_val, 16'h0000);
        // Periods: a 16, b 32, c 8 clocks
        wr_reg(dual_pwm_pkg::TIMER_A_LIMIT_OFS, 16'h0003);
        wr_reg(dual_pwm_pkg::TIMER_B_LIMIT_OFS, 16'h0007);
        wr_reg(dual_pwm_pkg::TIMER_C_LIMIT_OFS, 16'h0001);
        wr_reg(dual_pwm_pkg::PWM_A_DUTY_OFS, duty_word(10'd5));
        wr_reg(dual_pwm_pkg::PWM_B_DUTY_OFS, duty_word(10'd10));
        wr_reg(dual_pwm_pkg::TIMER_SEL_OFS, 16'h00d9);
        // Capture codes are registered once more after the select register
        @(posedge i_clock);
        #1;
        check_val({14'h0, o_cap2_timer_sel}, 16'h0002);
        wr_reg(dual_pwm_pkg::TIMER_RUN_OFS, 16'h0001);
        measure(0, 0);
        wr_reg(dual_pwm_pkg::PWM_A_CONTROL_OFS, 16'h0080);
        wr_reg(dual_pwm_pkg::PWM_B_CONTROL_OFS, 16'h0080);
        measure(20, 64);
        wr_reg(dual_pwm_pkg::PWM_A_CONTROL_OFS, 16'h0090);
        measure(44, -1);
        wr_reg(dual_pwm_pkg::TIMER_SEL_OFS, 16'h00e9);
        measure(54, -1);
        wr_reg(dual_pwm_pkg::PWM_A_CONTROL_OFS, 16'h0080);
        measure(10, -1);
        wr_reg(dual_pwm_pkg::TIMER_SEL_OFS, 16'h00c9);
        measure(0, 64);
        wr_reg(dual_pwm_pkg::PWM_A_CONTROL_OFS, 16'h007f);
        measure(64, -1);
        rd_reg(dual_pwm_pkg::PWM_A_CONTROL_OFS, rd_val);
        check_val(rd_val, 16'h0030);
        // Freeze mid-period; the pin must hold its level
        wr_reg(dual_pwm_pkg::TIMER_SEL_OFS, 16'h00d9);
        wr_reg(dual_pwm_pkg::PWM_A_CONTROL_OFS, 16'h0080);
        repeat (103) @(posedge i_clock);
        i_sleep <= 1'b1;
        repeat (4) @(posedge i_clock);
        #1 pin_now = o_pwm_a;
        measure(pin_now ? 64 : 0, -1);
        @(posedge i_clock);
        i_sleep <= 1'b0;
        measure(20, -1);
        // Channel b on timer b (32 clocks), timer a (16 clocks), then reserved
        wr_reg(dual_pwm_pkg::TIMER_SEL_OFS, 16'h0099);
        measure(20, 20);
        wr_reg(dual_pwm_pkg::TIMER_SEL_OFS, 16'h0059);
        measure(-1, 40);
        wr_reg(dual_pwm_pkg::TIMER_SEL_OFS, 16'h0019);
        measure(-1, 0);
        // Capture pair codes 1 to 3 on both units, reserved code 0 not driven
        for (int c = 1; c < 4; c++)
        begin
            wr_reg(dual_pwm_pkg::TIMER_SEL_OFS, {8'h00, 4'hd, 2'(c), 2'(c)});
            @(posedge i_clock);
            #1;
            check_val({14'h0, o_cap1_timer_sel}, 16'(c));
            check_val({14'h0, o_cap2_timer_sel}, 16'(c));
        end
        wr_reg(dual_pwm_pkg::PWM_A_DUTY_OFS, 16'habff);
        rd_reg(dual_pwm_pkg::PWM_A_DUTY_OFS, rd_val);
        check_val(rd_val, 16'habc0);
        // Duty survives a mid-run reset, the rest returns to defaults
        @(posedge i_clock);
        i_srst <= 1'b1;
        repeat (3) @(posedge i_clock);
        i_srst <= 1'b0;
        rd_reg(dual_pwm_pkg::PWM_A_DUTY_OFS, rd_val);
        check_val(rd_val, 16'habc0);
        rd_reg(dual_pwm_pkg::PWM_B_DUTY_OFS, rd_val);
        check_val(rd_val, duty_word(10'd10));
        rd_reg(dual_pwm_pkg::TIMER_SEL_OFS, rd_val);
        check_val(rd_val, 16'h0055);
        check_val({14'h0, o_cap1_timer_sel}, 16'h0001);
        complete_run();
    end
endmodule
